// file: hdl/psitx_pkg.sv
// Constants, field layouts and carrier types of the PSI5 sync detector
// and frame transmitter. Assumes a 125 MHz system clock.
// Summary of operation
// - Replies only by modulating drawn current.
// - Wait programmed slot delay before frame.
// - Valid sync keeps trigger reference timers running.
// - Count high samples; qualify at fixed time.
// - First high sample starts all timers.
// - Valid sync blanks detector for chosen time.
// - Valid sync holds sync filter in reset.
// - Failed sync resets timers, rearms next sample.
// - Pulldown sinks current after delay, on-time.
// - Pulldown off in programming, init1, pre-run daisy.
// - Manchester: zero rises, one falls mid-bit.
// - Mid-bit edge always; boundary edge on repeats.
// - Two start bits, data LSB first, check.
// - Config bit picks parity or 3-bit CRC.
// - Parity makes count of ones even.
// - CRC x^3+x+1, seed 111.
// - CRC over data LSB first plus three zeros.
// - Data field size follows payload format field.
// - Send 1F4h for defect; never reserved codes.

package psitx_pkg;
	localparam int CLK_NS      = 8;
	localparam int US_CYC      = 1000 / CLK_NS;
	localparam int SAMP_NS     = 256;
	localparam int SAMP_CYC    = (SAMP_NS + CLK_NS - 1) / CLK_NS;
	localparam int QUAL_NS     = 4000;
	localparam int QUAL_CYC    = (QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int MIN_SYNC_NS = 2500;
	localparam int MIN_CNT     = MIN_SYNC_NS / SAMP_NS;
	localparam int LPF_RST_NS  = 8000;
	localparam int LPF_CYC     = (LPF_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int PD_DLY_NS   = 6000;
	localparam int PD_DLY_CYC  = (PD_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int PD_ON_NS    = 4000;
	localparam int PD_ON_CYC   = PD_ON_NS / CLK_NS;
	localparam int BIT125_NS   = 8000;
	localparam int BIT189_NS   = 5291;
	localparam int HALF125_CYC = BIT125_NS / 2 / CLK_NS;
	localparam int HALF189_CYC = BIT189_NS / 2 / CLK_NS;
	localparam int BLANK0_US   = 100;
	localparam int BLANK1_US   = 150;
	localparam int BLANK2_US   = 200;
	localparam int BLANK3_US   = 250;
	// Register byte offsets
	localparam logic [7:0] REG_CFG  = 8'h00;
	localparam logic [7:0] REG_SLOT = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	// Fields of link_protocol_config
	localparam int CFG_CRC  = 0;
	localparam int CFG_PD   = 1;
	localparam int CFG_MODE = 2;
	localparam int CFG_RUN  = 4;
	localparam int CFG_RATE = 5;
	localparam int CFG_BLK  = 6;
	localparam int CFG_FMT  = 8;
	localparam logic [8:0]  CFG_RST  = 9'h000;
	localparam logic [15:0] SLOT_RST = 16'h0032;
	localparam logic [9:0]  DATA_RST = 10'h000;
	localparam logic [9:0]  DEFECT   = 10'h1f4;
	localparam logic [9:0]  RSV_LO   = 10'h1f1;
	localparam logic [1:0]  MODE_NORMAL = 2'h0;
	localparam logic [1:0]  MODE_PROG   = 2'h1;
	localparam logic [1:0]  MODE_INIT1  = 2'h2;
	localparam logic [1:0]  MODE_DAISY  = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_QUAL = 2'b01,
		ST_WAIT = 2'b10,
		ST_SEND = 2'b11
	} psitx_state_t;

	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} psitx_ahb_req_t;

	typedef struct packed {
		psitx_state_t st;
		logic [23:0]  tcnt;
		logic [5:0]   scnt;
		logic [7:0]   wcnt;
		logic         sent;
		logic [4:0]   bitc;
		logic         half;
		logic [9:0]   hcnt;
		logic [15:0]  frame;
		logic         sink;
		logic         lpf;
		logic         valid;
		logic [8:0]   cfg;
		logic [15:0]  slot;
		logic [9:0]   data;
		logic         dwr;
		logic [7:0]   daddr;
		logic [31:0]  hrdata;
		logic         hreadyout;
	} psitx_regs_t;
endpackage : psitx_pkg

// file: hdl/psitx_core.sv
// PSI5 slave link: sync pulse qualification, pulldown, Manchester frames.
// Assumes the sync comparator is asynchronous and AHB-Lite is on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module psitx_core (
	input  wire logic                     sys_clk_in,
	input  wire logic                     arst_n_in,
	input  wire logic                     sync_comp_in,
	input  wire psitx_pkg::psitx_ahb_req_t ahb_req_in,
	output logic [31:0]                   hrdata_out,
	output logic                          hreadyout_out,
	output logic                          hresp_out,
	output logic                          mod_sink_out,
	output logic                          sync_valid_out,
	output logic                          sync_filter_reset_out
);
	psitx_pkg::psitx_regs_t s;
	psitx_pkg::psitx_regs_t n;
	logic                   comp_m;
	logic                   comp_s;
	logic                   pd_ok;
	logic [23:0]            slot_cyc;
	logic [23:0]            blank_cyc;
	logic [9:0]             half_cyc;

	// Microseconds to clock cycles
	function automatic logic [23:0] us_cyc(input logic [15:0] us);
		us_cyc = 24'(us) * 24'(psitx_pkg::US_CYC);
	endfunction : us_cyc

	// Augmented CRC: data LSB first, then three zeros, seed 111
	function automatic logic [2:0] crc3(input logic [9:0] d,
		input logic [3:0] len);
		logic [2:0] r;
		r = 3'h7;
		for (int i = 0; i < 13; i++) begin
			if (i < int'(len)) begin
				r = {r[1:0], d[i]} ^ (r[2] ? 3'h3 : 3'h0);
			end else if (i >= 10) begin
				r = {r[1:0], 1'b0} ^ (r[2] ? 3'h3 : 3'h0);
			end
		end
		crc3 = r;
	endfunction : crc3

	// Comparator comes from the analog side: two flops before use
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comp_m <= 1'b0;
			comp_s <= 1'b0;
		end else begin
			comp_m <= sync_comp_in;
			comp_s <= comp_m;
		end
	end

	// Pulldown is forbidden in programming, init1 and daisy before run
	assign pd_ok = s.cfg[psitx_pkg::CFG_PD] &&
		s.cfg[psitx_pkg::CFG_MODE +: 2] != psitx_pkg::MODE_PROG &&
		s.cfg[psitx_pkg::CFG_MODE +: 2] != psitx_pkg::MODE_INIT1 &&
		!(s.cfg[psitx_pkg::CFG_MODE +: 2] == psitx_pkg::MODE_DAISY &&
		!s.cfg[psitx_pkg::CFG_RUN]);
	assign slot_cyc = us_cyc(s.slot);
	assign half_cyc = s.cfg[psitx_pkg::CFG_RATE] ?
		10'(psitx_pkg::HALF189_CYC) : 10'(psitx_pkg::HALF125_CYC);

	// Blanking length from the command blocking selection
	always_comb begin
		case (s.cfg[psitx_pkg::CFG_BLK +: 2])
			2'h0:    blank_cyc = us_cyc(16'(psitx_pkg::BLANK0_US));
			2'h1:    blank_cyc = us_cyc(16'(psitx_pkg::BLANK1_US));
			2'h2:    blank_cyc = us_cyc(16'(psitx_pkg::BLANK2_US));
			default: blank_cyc = us_cyc(16'(psitx_pkg::BLANK3_US));
		endcase
	end

	// Next state of the whole block
	always_comb begin
		logic [9:0]  dd;
		logic [3:0]  len;
		logic [2:0]  ck;
		logic        par;
		logic        crc_on;
		logic        tick;
		n = s;
		ck = 3'h0;
		par = 1'b0;
		dd = s.data;
		crc_on = s.cfg[psitx_pkg::CFG_CRC];
		len = s.cfg[psitx_pkg::CFG_FMT] ? 4'h8 : 4'ha;
		tick = (s.scnt == 6'(psitx_pkg::SAMP_CYC - 1));
		n.valid = 1'b0;
		n.scnt = tick ? 6'h00 : s.scnt + 6'h01;
		// Reserved top of the positive range collapses to the defect code;
		// negative codes (bit 9 set) are ordinary data and pass untouched
		if (!s.cfg[psitx_pkg::CFG_FMT] && !dd[9] &&
			dd >= psitx_pkg::RSV_LO && dd != psitx_pkg::DEFECT) begin
			dd = psitx_pkg::DEFECT;
		end
		if (s.cfg[psitx_pkg::CFG_FMT]) begin
			dd = {2'h0, dd[7:0]};
		end
		ck = crc3(dd, len);
		par = ^dd;
		if (s.tcnt != 24'hffffff) begin
			n.tcnt = s.tcnt + 24'h000001;
		end
		case (s.st)
			psitx_pkg::ST_IDLE: begin
				// First high sample is the trigger reference
				if (tick && comp_s) begin
					n.st = psitx_pkg::ST_QUAL;
					n.tcnt = 24'h000000;
					n.wcnt = 8'h01;
					n.sent = 1'b0;
				end
			end
			psitx_pkg::ST_QUAL: begin
				if (tick && comp_s) begin
					n.wcnt = s.wcnt + 8'h01;
				end
				if (s.tcnt == 24'(psitx_pkg::QUAL_CYC)) begin
					if (s.wcnt > 8'(psitx_pkg::MIN_CNT)) begin
						n.st = psitx_pkg::ST_WAIT;
						n.valid = 1'b1;
						n.wcnt = 8'h00;
					end else begin
						n.st = psitx_pkg::ST_IDLE;
						n.tcnt = 24'h000000;
						n.wcnt = 8'h00;
					end
				end
			end
			psitx_pkg::ST_WAIT: begin
				// Detector stays blind until blanking ends
				if (!s.sent && s.tcnt >= slot_cyc) begin
					n.st = psitx_pkg::ST_SEND;
					n.half = 1'b0;
					n.hcnt = 10'h000;
					n.bitc = 5'(len) + (crc_on ? 5'h05 : 5'h03);
					if (crc_on && !s.cfg[psitx_pkg::CFG_FMT]) begin
						n.frame = {1'b0, ck[0], ck[1], ck[2], dd, 2'b00};
					end else if (crc_on) begin
						n.frame = {3'h0, ck[0], ck[1], ck[2], dd[7:0], 2'b00};
					end else if (!s.cfg[psitx_pkg::CFG_FMT]) begin
						n.frame = {3'h0, par, dd, 2'b00};
					end else begin
						n.frame = {5'h00, par, dd[7:0], 2'b00};
					end
				end else if (s.sent && s.tcnt >= blank_cyc) begin
					n.st = psitx_pkg::ST_IDLE;
				end
			end
			psitx_pkg::ST_SEND: begin
				// Half-bit timer; the bit advances after its second half
				if (s.hcnt == half_cyc - 10'h001) begin
					n.hcnt = 10'h000;
					n.half = ~s.half;
					if (s.half) begin
						n.frame = {1'b0, s.frame[15:1]};
						n.bitc = s.bitc - 5'h01;
						if (s.bitc == 5'h01) begin
							n.st = psitx_pkg::ST_WAIT;
							n.sent = 1'b1;
						end
					end
				end else begin
					n.hcnt = s.hcnt + 10'h001;
				end
			end
			default: n.st = psitx_pkg::ST_IDLE;
		endcase
		// A one sinks in the first half, a zero in the second
		if (s.st == psitx_pkg::ST_SEND) begin
			n.sink = s.half ? ~s.frame[0] : s.frame[0];
		end else if (s.st == psitx_pkg::ST_WAIT && pd_ok) begin
			n.sink = s.tcnt >= 24'(psitx_pkg::PD_DLY_CYC) &&
				s.tcnt < 24'(psitx_pkg::PD_DLY_CYC + psitx_pkg::PD_ON_CYC);
		end else begin
			n.sink = 1'b0;
		end
		n.lpf = (n.st == psitx_pkg::ST_WAIT || n.st == psitx_pkg::ST_SEND)
			&& n.tcnt < 24'(psitx_pkg::LPF_CYC);
		// Bus data phase: write lands before the read mux looks
		if (s.dwr) begin
			case (s.daddr)
				psitx_pkg::REG_CFG:  n.cfg = ahb_req_in.hwdata[8:0];
				psitx_pkg::REG_SLOT: n.slot = ahb_req_in.hwdata[15:0];
				psitx_pkg::REG_DATA: n.data = ahb_req_in.hwdata[9:0];
				default:             n.cfg = s.cfg;
			endcase
		end
		n.dwr = 1'b0;
		n.hreadyout = 1'b1;
		if (ahb_req_in.hsel && ahb_req_in.htrans[1] && ahb_req_in.hready) begin
			n.dwr = ahb_req_in.hwrite;
			n.daddr = ahb_req_in.haddr;
			case (ahb_req_in.haddr)
				psitx_pkg::REG_CFG:  n.hrdata = {23'h0, n.cfg};
				psitx_pkg::REG_SLOT: n.hrdata = {16'h0, n.slot};
				psitx_pkg::REG_DATA: n.hrdata = {22'h0, n.data};
				psitx_pkg::REG_STAT: n.hrdata = {20'h0, s.wcnt, s.lpf,
					s.sent, s.st};
				default:             n.hrdata = 32'h0;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s <= '{st: psitx_pkg::ST_IDLE, cfg: psitx_pkg::CFG_RST,
				slot: psitx_pkg::SLOT_RST, data: psitx_pkg::DATA_RST,
				hreadyout: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign hrdata_out = s.hrdata;
	assign hreadyout_out = s.hreadyout;
	assign hresp_out = 1'b0;
	assign mod_sink_out = s.sink;
	assign sync_valid_out = s.valid;
	assign sync_filter_reset_out = s.lpf;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	a_valid_after_qual: assert property (
		s.valid |-> $past(s.st) == psitx_pkg::ST_QUAL &&
		$past(s.tcnt) == 24'(psitx_pkg::QUAL_CYC))
		else $error("valid sync without qualification");
	a_fail_rearm: assert property (
		(s.st == psitx_pkg::ST_QUAL && s.tcnt == 24'(psitx_pkg::QUAL_CYC)
		&& s.wcnt <= 8'(psitx_pkg::MIN_CNT)) |=>
		s.st == psitx_pkg::ST_IDLE && s.tcnt == 24'h0 && !s.valid)
		else $error("short sync not rejected");
	a_trigger_zero: assert property (
		(s.st == psitx_pkg::ST_QUAL && $past(s.st) == psitx_pkg::ST_IDLE)
		|-> s.tcnt == 24'h0 && s.wcnt == 8'h01)
		else $error("timers not started at trigger");
	a_slot_wait: assert property (
		$rose(s.st == psitx_pkg::ST_SEND) |-> s.tcnt > slot_cyc)
		else $error("frame began before slot");
	a_pd_blocked: assert property (
		(s.st == psitx_pkg::ST_WAIT && !pd_ok) |=> !s.sink)
		else $error("pulldown while blocked");
	a_one_frame: assert property (
		(s.st == psitx_pkg::ST_WAIT && s.sent) |=>
		s.st != psitx_pkg::ST_SEND)
		else $error("second frame for one sync");
	a_blank_hold: assert property (
		(s.st == psitx_pkg::ST_WAIT && s.tcnt < blank_cyc) |=>
		s.st != psitx_pkg::ST_QUAL && s.st != psitx_pkg::ST_IDLE)
		else $error("detector rearmed during blanking");
	a_lpf_hold: assert property (
		s.valid |-> s.lpf [*8])
		else $error("filter reset not held");
	a_idle_quiet: assert property (
		$past(s.st) == psitx_pkg::ST_IDLE |-> !s.sink)
		else $error("current drawn while idle");

	c_valid_sync: cover property (s.valid);
	c_reject: cover property (s.st == psitx_pkg::ST_QUAL ##1
		s.st == psitx_pkg::ST_IDLE);
	c_crc_frame: cover property ($rose(s.st == psitx_pkg::ST_SEND) &&
		s.cfg[psitx_pkg::CFG_CRC]);
	c_pulldown: cover property (s.st == psitx_pkg::ST_WAIT && s.sink);
endmodule : psitx_core

`default_nettype wire

// file: dv/psitx_master_model.sv
// Master side model: drives the sync comparator level seen by the block.
// Assumes it is called from the bench right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module psitx_master_model (
	input  wire logic sys_clk_in,
	output var  logic sync_comp_out
);
	initial sync_comp_out = 1'h0;

	// Raise the supply above the sync threshold, then drop back
	task automatic pulse(input int cyc);
		sync_comp_out <= 1'h1;
		repeat (cyc) @(posedge sys_clk_in);
		sync_comp_out <= 1'h0; // Comparator always drives, no float
	endtask : pulse
endmodule : psitx_master_model

`default_nettype wire

// file: dv/test_psi5_sync_and_frame_transmitter.sv
// Self-checking bench: register access, sync qualification and frames.
// Assumes the master model drives the comparator; AHB master lives here.
`timescale 1ns/1ps
`default_nettype none

module test_psi5_sync_and_frame_transmitter;
	typedef struct packed {
		logic [8:0] cfg;
		logic [9:0] data;
		logic       pd;
	} psitx_row_t;
	localparam int LIMIT = 100000;
	// Config, data word, expected pulldown in its window
	localparam psitx_row_t ROWS [6] = '{
		'{9'h000, 10'h0cc, 1'h0}, '{9'h023, 10'h151, 1'h1},
		'{9'h027, 10'h1f8, 1'h0}, '{9'h13f, 10'h3a5, 1'h1},
		'{9'h02e, 10'h3ff, 1'h0}, '{9'h02b, 10'h1f4, 1'h0}};

	logic                      clk    = 1'h0;
	logic                      arst_n = 1'h0;
	logic                      comp;
	psitx_pkg::psitx_ahb_req_t req;
	psitx_pkg::psitx_ahb_req_t ahb;
	logic [31:0]               hrdata;
	logic                      hready;
	logic                      hresp;
	logic                      sink;
	logic                      valid;
	logic                      lpf;
	logic [31:0]               rd;
	int                        miscompares = 0;
	int                        compares    = 0;
	int                        cycles      = 0;
	int                        nvalid      = 0;

	always #4 clk = ~clk;

	// The only slave's ready is the bus ready
	always_comb begin
		ahb = req;
		ahb.hready = hready;
	end

	psitx_core u_dut (
		.sys_clk_in           (clk),
		.arst_n_in            (arst_n),
		.sync_comp_in         (comp),
		.ahb_req_in           (ahb),
		.hrdata_out           (hrdata),
		.hreadyout_out        (hready),
		.hresp_out            (hresp),
		.mod_sink_out         (sink),
		.sync_valid_out       (valid),
		.sync_filter_reset_out(lpf)
	);

	psitx_master_model u_master (
		.sys_clk_in   (clk),
		.sync_comp_out(comp)
	);

	// Valid-sync pulses and the hang guard
	always @(posedge clk) begin
		if (valid === 1'h1)
			nvalid <= nvalid + 1;
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// One AHB-Lite single word transfer, entered just after an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		req <= '{hsel: 1'h1, haddr: a, htrans: 2'h2, hwrite: wr,
			hsize: 3'h2, hwdata: req.hwdata, hready: 1'h0};
		do @(posedge clk); while (hready !== 1'h1);
		req <= '{hwdata: wd, default: '0};
		do @(posedge clk); while (hready !== 1'h1);
		r = hrdata;
	endtask : bus

	task automatic wait_valid();
		for (int i = 0; i < 300 && valid !== 1'h1; i++)
			@(posedge clk);
	endtask : wait_valid

	// Frame bits in send order; reserved codes fold to the defect code
	function automatic logic [15:0] frame_bits(input logic [8:0] c,
		input logic [9:0] d);
		logic [15:0] f;
		logic [2:0]  r;
		logic [9:0]  v;
		int          n;
		n = c[8] ? 8 : 10;
		v = (!c[8] && d > 10'h1f0 && d < 10'h200 && d != 10'h1f4) ?
			10'h1f4 : d;
		f = '0;
		r = 3'h7;
		for (int i = 0; i < n; i++) begin
			f[2 + i] = v[i];
			r = {r[1:0], v[i]} ^ (r[2] ? 3'h3 : 3'h0);
		end
		for (int i = 0; i < 3; i++)
			r = {r[1:0], 1'h0} ^ (r[2] ? 3'h3 : 3'h0);
		if (c[0])
			f[2 + n +: 3] = {r[0], r[1], r[2]};
		else
			f[2 + n] = ^(v & (c[8] ? 10'h0ff : 10'h3ff));
		return f;
	endfunction : frame_bits

	initial begin
		logic [15:0] f;
		logic [31:0] cap;
		logic [31:0] e;
		int          h;
		int          nb;
		int          i;
		int          j;
		req = '0;
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		bus(1'h1, psitx_pkg::REG_SLOT, 32'h14, rd); // 20 us slot
		// Ordinary frames, one row per sync pulse
		foreach (ROWS[r]) begin
			bus(1'h1, psitx_pkg::REG_CFG, 32'(ROWS[r].cfg), rd);
			bus(1'h1, psitx_pkg::REG_DATA, 32'(ROWS[r].data), rd);
			h = ROWS[r].cfg[5] ? psitx_pkg::HALF189_CYC : psitx_pkg::HALF125_CYC;
			nb = (ROWS[r].cfg[8] ? 10 : 12) + (ROWS[r].cfg[0] ? 3 : 1);
			f = frame_bits(ROWS[r].cfg, ROWS[r].data);
			cap = '0;
			e = '0;
			u_master.pulse(438);
			wait_valid();
			check(valid, 1'h1);
			repeat (400) @(posedge clk);
			check(sink, ROWS[r].pd);
			check(lpf, 1'h1);
			repeat (500) @(posedge clk);
			check({lpf, sink}, 2'h0);
			for (i = 0; i < 3000 && sink !== 1'h1; i++)
				@(posedge clk);
			check(32'(i >= h + 1080 && i <= h + 1120), 32'h1);
			// Sample each half bit in its centre, after the first mid-bit rise
			repeat (h / 2) @(posedge clk);
			for (int k = 0; k < 2 * nb - 1; k++) begin
				j = k + 1;
				e[k] = f[j / 2] ^ j[0];
				cap[k] = sink;
				repeat (h) @(posedge clk);
			end
			check(cap, e);
			// Poll status until the detector is rearmed after blanking
			do
				bus(1'h0, psitx_pkg::REG_STAT, 32'h0, rd);
			while (rd[1:0] !== 2'h0);
			check(rd[3:0], 4'h4);
			$display("frame row %0d done", r);
		end
		// Second reset in mid-run, then reset values and access kinds
		arst_n <= 1'h0;
		repeat (3) @(posedge clk);
		check({27'h0, hready, hresp, sink, valid, lpf}, 32'h10);
		check(hrdata, 32'h0);
		arst_n <= 1'h1;
		@(posedge clk);
		bus(1'h1, psitx_pkg::REG_STAT, 32'hfff, rd);
		bus(1'h1, 8'h10, 32'hffff_ffff, rd);
		for (i = 0; i < 5; i++) begin
			bus(1'h0, 8'(i * 4), 32'h0, rd);
			check(rd, i == 1 ? 32'h32 : 32'h0);
		end
		// Faster rate, short slot and the second blanking choice
		bus(1'h1, psitx_pkg::REG_SLOT, 32'h14, rd);
		bus(1'h1, psitx_pkg::REG_CFG, 32'h60, rd);
		bus(1'h0, psitx_pkg::REG_CFG, 32'h0, rd);
		check(rd, 32'h60);
		$display("reset and registers done");
		// Short pulse fails, detector rearms, pulse in blanking ignored
		i = nvalid;
		u_master.pulse(188);
		repeat (700) @(posedge clk);
		check(32'(nvalid - i), 32'h0);
		u_master.pulse(438);
		wait_valid();
		check(valid, 1'h1);
		repeat (100) @(posedge clk);
		i = nvalid;
		u_master.pulse(438);
		repeat (1000) @(posedge clk);
		check(32'(nvalid - i), 32'h0);
		// Frame is over and the shortest blanking has expired, the chosen
		// one has not: the detector must still be blind
		repeat (10700) @(posedge clk);
		i = nvalid;
		u_master.pulse(438);
		repeat (700) @(posedge clk);
		check(32'(nvalid - i), 32'h0);
		$display("sync qualification done");
		print_verdict();
	end
endmodule : test_psi5_sync_and_frame_transmitter

`default_nettype wire
